// *** rtl/ubt_uart_tx.sv ***
// ubt_uart_tx: one uart channel transmitter with baud divider, prescaler and interrupt pin
// assumes one 20 MHz clock standing in for the oscillator; apb from the same clock
// Function
// R1: fifo off: interrupt low while holding register full, high when empty; with half-duplex on the code goes high only when the transmitter is empty
// R2: fifo on, half-duplex off: low above trigger, high below or empty
// R3: fifo on, half-duplex on: low above trigger, high below or transmitter empty
// R4: fifo on: receiver part low below rx trigger, high above it
// R5: oscillator clocks only baud logic; register access needs none; the code clocks the registers and apb from the same clk
// R6: prescaler divides by 1 or 4; control bit 7 overrides pin once written
// R7: baud divider divides prescaler output by 16-bit divisor 1..65535
// R8: sampling clock is 16x rate when pin high, 8x when low
// R9: host writes divisor high and low bytes separately
// R10: one divider feeds transmitter and receiver of the channel
// R11: transmitter shifts on sampling clock, receiver samples on it
// R12: each bit lasts 16 sampling periods, or 8 in 8x mode
// R13: frame is start, data bits, optional parity, stop bits
// R14: bit 0 of byte goes out first
// R15: holding register is 8-bit write-only data input
// R16: fifo enable bit 0 routes writes into 128-byte fifo
// R17: every holding write advances fifo write pointer; the code drops a holding write while the fifo is full
// R18: non-fifo: holding-empty bit 5 set when byte moves to shifter
// R19: holding-empty raises status bit 1 interrupt only if enable bit 1 set
// R20: transmitter-empty bit 6 set only after stop bits finish
// R21: host writes one character at a time in non-fifo mode
// R22: half-duplex mode active only after feature bit 3 set; off at reset
// R23: interrupt pin combines only enabled sources; divisor zero stops baud
module ubt_uart_tx (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  input  wire logic        prescalerSelectPin,
  input  wire logic        samplingRateSelectPin,
  input  wire logic        rxAboveTrigger,
  output logic             txSerialOut,
  output logic             channelInterruptPinN,
  output logic             sampleTick
);
  // pin synchronisers
  logic [1:0] preSync_q, rateSync_q, rxTrgSync_q;
  always_ff @(posedge clk) begin
    preSync_q   <= {preSync_q[0], prescalerSelectPin};
    rateSync_q  <= {rateSync_q[0], samplingRateSelectPin};
    rxTrgSync_q <= {rxTrgSync_q[0], rxAboveTrigger};
  end

  // registers
  logic [7:0]  ier_q, lcr_q, feature_control_register_q, trg_q;
  logic        fifoEn_q, mcrPre_q, mcrWritten_q;
  logic [15:0] div_q;
  logic        apbWr, apbRd;
  assign apbWr = psel && penable && pwrite; // R5
  assign apbRd = psel && penable && !pwrite;

  ubt_pkg::ubt_cfg_t cfg;
  assign cfg.fifoEn     = fifoEn_q;
  assign cfg.halfDuplex = feature_control_register_q[ubt_pkg::FEATURE_CONTROL_REGISTER_HDX_BIT]; // R22
  assign cfg.parityEn   = lcr_q[ubt_pkg::LCR_PEN_BIT];
  assign cfg.parityEven = lcr_q[ubt_pkg::LCR_EPS_BIT];
  assign cfg.twoStop    = lcr_q[ubt_pkg::LCR_STB_BIT];
  assign cfg.wordLen    = lcr_q[1:0];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ier_q        <= ubt_pkg::IER_RST;
      lcr_q        <= ubt_pkg::LCR_RST;
      feature_control_register_q       <= ubt_pkg::FEATURE_CONTROL_REGISTER_RST;
      trg_q        <= ubt_pkg::TRG_RST;
      fifoEn_q     <= ubt_pkg::FCR_RST[0];
      mcrPre_q     <= 1'b0;
      mcrWritten_q <= 1'b0;
      div_q        <= ubt_pkg::DIV_RST;
    end else if (apbWr) begin
      unique case (paddr)
        ubt_pkg::ADDR_IER:  ier_q <= pwdata[7:0];
        ubt_pkg::ADDR_FCR:  fifoEn_q <= pwdata[ubt_pkg::FCR_EN_BIT]; // R16
        ubt_pkg::ADDR_LCR:  lcr_q <= pwdata[7:0];
        ubt_pkg::ADDR_MCR: begin
          mcrPre_q     <= pwdata[ubt_pkg::MCR_PRE_BIT]; // R6
          mcrWritten_q <= 1'b1;
        end
        ubt_pkg::ADDR_DLL:  div_q[7:0]  <= pwdata[7:0]; // R9
        ubt_pkg::ADDR_DLM:  div_q[15:8] <= pwdata[7:0]; // R9
        ubt_pkg::ADDR_FEATURE_CONTROL_REGISTER: feature_control_register_q <= pwdata[7:0];
        ubt_pkg::ADDR_TRG:  trg_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // prescaler: divide by 1 or 4
  logic       preDiv4;
  logic [2:0] preCnt_q;
  logic       preTick;
  assign preDiv4 = mcrWritten_q ? mcrPre_q : preSync_q[1]; // R6
  assign preTick = !preDiv4 || (preCnt_q == ubt_pkg::PRE4 - 3'h1);
  always_ff @(posedge clk) begin
    if (!rstn || preTick) preCnt_q <= 3'h0;
    else                  preCnt_q <= preCnt_q + 3'h1;
  end

  // baud divider, shared sampling tick for tx and rx
  logic [15:0] divCnt_q;
  logic        baudTick;
  assign baudTick = preTick && (div_q != 16'h0000) && (divCnt_q == div_q - 16'h0001); // R7 R23
  always_ff @(posedge clk) begin
    if (!rstn) divCnt_q <= 16'h0000;
    else if (preTick) divCnt_q <= baudTick || (divCnt_q >= div_q) ? 16'h0000 : divCnt_q + 16'h0001; // R7
  end
  always_ff @(posedge clk) begin
    if (!rstn) sampleTick <= 1'b0;
    else       sampleTick <= baudTick; // R10 R11
  end

  // transmit fifo; depth 1 behaviour when disabled
  logic [7:0]         mem [ubt_pkg::FIFO_DEPTH];
  logic [ubt_pkg::PTR_W-1:0] wrPtr_q, rdPtr_q;
  logic [ubt_pkg::PTR_W:0]   level_q;
  logic               push, pop, fifoFull;
  assign fifoFull = cfg.fifoEn ? (level_q == 8'(ubt_pkg::FIFO_DEPTH)) : (level_q != 8'h00);
  assign push = apbWr && (paddr == ubt_pkg::ADDR_THR) && !fifoFull; // R15
  always_ff @(posedge clk) begin
    if (push) mem[wrPtr_q] <= pwdata[7:0]; // R15
  end
  always_ff @(posedge clk) begin
    if (!rstn || (apbWr && paddr == ubt_pkg::ADDR_FCR)) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      level_q <= '0;
    end else begin
      if (push) wrPtr_q <= wrPtr_q + 7'h01; // R16 R17
      if (pop)  rdPtr_q <= rdPtr_q + 7'h01;
      level_q <= level_q + {7'h00, push} - {7'h00, pop};
    end
  end

  // transmitter
  ubt_pkg::ubt_txst_t st_q;
  logic [4:0] bitTick_q;
  logic [4:0] ovs;
  logic [7:0] shift_q;
  logic [3:0] bitIdx_q, nData;
  logic       parity_q, stop2_q, bitEnd;
  assign ovs    = rateSync_q[1] ? ubt_pkg::OVS16 : ubt_pkg::OVS8; // R8 R12
  assign bitEnd = baudTick && (bitTick_q == ovs - 5'h01); // R12
  assign nData  = 4'h5 + {2'b00, cfg.wordLen};
  assign pop    = (st_q == ubt_pkg::TX_IDLE) && (level_q != 8'h00) && baudTick; // R18
  always_ff @(posedge clk) begin
    if (!rstn || st_q == ubt_pkg::TX_IDLE) bitTick_q <= 5'h00;
    else if (baudTick) bitTick_q <= bitEnd ? 5'h00 : bitTick_q + 5'h01; // R11
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q        <= ubt_pkg::TX_IDLE;
      txSerialOut <= 1'b1;
      shift_q     <= 8'h00;
      bitIdx_q    <= 4'h0;
      parity_q    <= 1'b0;
      stop2_q     <= 1'b0;
    end else begin
      unique case (st_q)
        ubt_pkg::TX_IDLE: if (pop) begin
          shift_q     <= mem[rdPtr_q]; // R18
          parity_q    <= !cfg.parityEven;
          txSerialOut <= 1'b0; // R13
          st_q        <= ubt_pkg::TX_START;
        end
        ubt_pkg::TX_START: if (bitEnd) begin
          txSerialOut <= shift_q[0]; // R14
          parity_q    <= parity_q ^ shift_q[0];
          shift_q     <= {1'b0, shift_q[7:1]};
          bitIdx_q    <= 4'h1;
          st_q        <= ubt_pkg::TX_DATA;
        end
        ubt_pkg::TX_DATA: if (bitEnd) begin
          if (bitIdx_q < nData) begin
            txSerialOut <= shift_q[0]; // R14
            parity_q    <= parity_q ^ shift_q[0];
            shift_q     <= {1'b0, shift_q[7:1]};
            bitIdx_q    <= bitIdx_q + 4'h1;
          end else if (cfg.parityEn && bitIdx_q == nData) begin
            txSerialOut <= parity_q; // R13
            bitIdx_q    <= bitIdx_q + 4'h1;
          end else begin
            txSerialOut <= 1'b1; // R13
            stop2_q     <= cfg.twoStop;
            st_q        <= ubt_pkg::TX_STOP;
          end
        end
        ubt_pkg::TX_STOP: if (bitEnd) begin
          if (stop2_q) stop2_q <= 1'b0;
          else         st_q <= ubt_pkg::TX_IDLE; // R20
        end
      endcase
    end
  end

  // status and interrupt
  logic thrEmpty, txEmpty, aboveTrg, txIntHigh, txIrq, rxIrq;
  assign thrEmpty = (level_q == 8'h00); // R18
  assign txEmpty  = thrEmpty && (st_q == ubt_pkg::TX_IDLE); // R20
  assign aboveTrg = level_q > {1'b0, trg_q[6:0]};
  always_comb begin
    if (!cfg.fifoEn)
      txIntHigh = cfg.halfDuplex ? txEmpty : thrEmpty; // R1
    else if (!cfg.halfDuplex)
      txIntHigh = !aboveTrg; // R2
    else
      txIntHigh = !aboveTrg || txEmpty; // R3
  end
  assign txIrq = txIntHigh && ier_q[ubt_pkg::IER_TXE_BIT]; // R19 R23
  assign rxIrq = cfg.fifoEn && rxTrgSync_q[1] && ier_q[ubt_pkg::IER_RXD_BIT]; // R4 R23
  always_ff @(posedge clk) begin
    if (!rstn) channelInterruptPinN <= 1'b0;
    else       channelInterruptPinN <= txIrq || rxIrq; // R1 R2 R3 R4
  end

  // apb read and answer; zero wait states
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          ubt_pkg::ADDR_IER:  prdata <= {24'h0, ier_q};
          ubt_pkg::ADDR_ISR:  prdata <= {29'h0, rxIrq, txIrq, !(txIrq || rxIrq)}; // R19
          ubt_pkg::ADDR_LCR:  prdata <= {24'h0, lcr_q};
          ubt_pkg::ADDR_MCR:  prdata <= {24'h0, mcrPre_q, 7'h00};
          ubt_pkg::ADDR_LSR:  prdata <= {25'h0, txEmpty, thrEmpty, 5'h00}; // R18 R20
          ubt_pkg::ADDR_DLL:  prdata <= {24'h0, div_q[7:0]};
          ubt_pkg::ADDR_DLM:  prdata <= {24'h0, div_q[15:8]};
          ubt_pkg::ADDR_FEATURE_CONTROL_REGISTER: prdata <= {24'h0, feature_control_register_q};
          ubt_pkg::ADDR_TRG:  prdata <= {24'h0, trg_q};
          ubt_pkg::ADDR_RXL:  prdata <= {24'h0, level_q};
          default:            prdata <= 32'h0000_0000;
        endcase
        if (paddr > ubt_pkg::ADDR_RXL || paddr[1:0] != 2'b00) pslverr <= 1'b1;
      end
    end
  end
endmodule

// *** rtl/ubt_pkg.sv ***
// ubt_pkg: register map, field positions, reset values and types for the uart tx channel
// assumes a 32-bit apb slave decoding word-aligned byte addresses
package ubt_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_THR  = 8'h00;
  localparam logic [7:0] ADDR_IER  = 8'h04;
  localparam logic [7:0] ADDR_ISR  = 8'h08;
  localparam logic [7:0] ADDR_FCR  = 8'h08;
  localparam logic [7:0] ADDR_LCR  = 8'h0C;
  localparam logic [7:0] ADDR_MCR  = 8'h10;
  localparam logic [7:0] ADDR_LSR  = 8'h14;
  localparam logic [7:0] ADDR_DLL  = 8'h18;
  localparam logic [7:0] ADDR_DLM  = 8'h1C;
  localparam logic [7:0] ADDR_FEATURE_CONTROL_REGISTER = 8'h20;
  localparam logic [7:0] ADDR_TRG  = 8'h24;
  localparam logic [7:0] ADDR_RXL  = 8'h28;
  // field positions
  localparam int IER_TXE_BIT   = 1;
  localparam int IER_RXD_BIT   = 0;
  localparam int ISR_TXE_BIT   = 1;
  localparam int ISR_RXD_BIT   = 2;
  localparam int FCR_EN_BIT    = 0;
  localparam int MCR_PRE_BIT   = 7;
  localparam int LSR_THRE_BIT  = 5;
  localparam int LSR_TEMT_BIT  = 6;
  localparam int FEATURE_CONTROL_REGISTER_HDX_BIT  = 3;
  localparam int LCR_PEN_BIT   = 3;
  localparam int LCR_EPS_BIT   = 4;
  localparam int LCR_STB_BIT   = 2;
  // reset values
  localparam logic [7:0]  IER_RST  = 8'h00;
  localparam logic [7:0]  FCR_RST  = 8'h00;
  localparam logic [7:0]  LCR_RST  = 8'h03;
  localparam logic [7:0]  FEATURE_CONTROL_REGISTER_RST = 8'h00;
  localparam logic [7:0]  TRG_RST  = 8'h20;
  localparam logic [15:0] DIV_RST  = 16'h0001;
  // structure
  localparam int FIFO_DEPTH = 128;
  localparam int PTR_W      = 7;
  localparam logic [4:0] OVS16 = 5'h10;
  localparam logic [4:0] OVS8  = 5'h08;
  localparam logic [2:0] PRE4  = 3'h4;

  typedef enum logic [3:0] {
    TX_IDLE   = 4'b0001,
    TX_START  = 4'b0010,
    TX_DATA   = 4'b0100,
    TX_STOP   = 4'b1000
  } ubt_txst_t;

  typedef struct packed {
    logic       fifoEn;
    logic       halfDuplex;
    logic       parityEn;
    logic       parityEven;
    logic       twoStop;
    logic [1:0] wordLen;
  } ubt_cfg_t;
endpackage

// *** tb/ubt_uart_tx_checker.sv ***
// ubt_uart_tx_checker: port-level assertions for the uart tx channel
// assumes apb transfers never overlap; bound to ubt_uart_tx
module ubt_uart_tx_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic        txSerialOut,
  input wire logic        channelInterruptPinN,
  input wire logic        sampleTick
);
  logic [15:0] divQ;
  logic [7:0]  ierQ;
  logic [2:0]  zeroCntQ;
  logic [2:0]  offCntQ;
  wire         wrEn = psel && penable && pwrite && pready;
  // shadow copies, since the checker cannot see the register file
  always_ff @(posedge clk) begin
    if (!rstn) begin
      divQ <= ubt_pkg::DIV_RST;
      ierQ <= ubt_pkg::IER_RST;
    end else if (wrEn) begin
      if (paddr == ubt_pkg::ADDR_DLL) divQ[7:0] <= pwdata[7:0];
      if (paddr == ubt_pkg::ADDR_DLM) divQ[15:8] <= pwdata[7:0];
      if (paddr == ubt_pkg::ADDR_IER) ierQ <= pwdata[7:0];
    end
  end
  // settle margin covers the pin synchronisers and output registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      zeroCntQ <= 3'h0;
      offCntQ  <= 3'h0;
    end else begin
      zeroCntQ <= (divQ != 16'h0000) ? 3'h0 : (zeroCntQ == 3'h7) ? zeroCntQ : zeroCntQ + 3'h1;
      offCntQ  <= (ierQ[1:0] != 2'h0) ? 3'h0 : (offCntQ == 3'h7) ? offCntQ : offCntQ + 3'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_start;
    $fell(txSerialOut);
  endsequence
  a_setup_ready: assert property (s_setup |=> pready) else $error("no ready");
  a_ready_once: assert property (pready |=> !pready) else $error("ready held");
  a_write_noerr: assert property (pready && pwrite |-> !pslverr) else $error("write err");
  a_read_hold: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
    else $error("prdata moved");
  a_start_len: assert property (s_start |-> !txSerialOut [*8]) else $error("short start");
  a_shift_tick: assert property ($changed(txSerialOut) |-> sampleTick || $past(sampleTick))
    else $error("shift off tick");
  a_zero_stop: assert property (zeroCntQ > 3'h3 |-> !sampleTick) else $error("tick at 0");
  a_irq_mask: assert property (offCntQ > 3'h3 |-> !channelInterruptPinN)
    else $error("irq unmasked");
endmodule

bind ubt_uart_tx ubt_uart_tx_checker chk_u (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .txSerialOut, .channelInterruptPinN, .sampleTick);

// *** tb/ubt_rx_model.sv ***
// ubt_rx_model: remote serial receiver sampling the tx line mid-bit
// assumes bitLen clocks per bit, 8 data bits, no parity, one stop bit
module ubt_rx_model (
  // clock
  input wire logic  clk,
  // serial line and bit length in clocks
  input wire logic  line,
  input var int     bitLen,
  // received character
  output logic [7:0] rxByte,
  output logic       stopOk,
  output int         frames
);
  initial begin
    frames = 0;
    forever begin
      @(negedge line);
      repeat (bitLen / 2) @(posedge clk);
      if (line === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (bitLen) @(posedge clk);
          rxByte[i] = line;
        end
        repeat (bitLen) @(posedge clk);
        stopOk = (line === 1'b1);
        frames++;
      end
    end
  end
endmodule

// *** tb/uart_baud_tx_interrupt_tb.sv ***
// uart_baud_tx_interrupt_tb: table-driven and directed checks of the uart tx channel
// assumes ubt_rx_model on the line and the checker bound to the dut
module uart_baud_tx_interrupt_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] b; logic rate; logic pre; logic [7:0] dv;} ubt_row_t;
  logic        clk, rstn, psel, penable, pwrite, preSel, rateSel, rxAbove;
  logic        pready, pslverr, er, txOut, irqPin, tick, stopOk;
  logic [7:0]  paddr, rxByte;
  logic [31:0] pwdata, prdata, rd;
  int          frames, bitLen, err_total, checks, n;
  ubt_row_t    rows [4] = '{{8'hA5, 1'b1, 1'b0, 8'h01}, {8'h01, 1'b0, 1'b0, 8'h02},
                            {8'h80, 1'b1, 1'b1, 8'h01}, {8'h3C, 1'b0, 1'b1, 8'h03}};
  ubt_uart_tx dut_u (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .prescalerSelectPin(preSel), .samplingRateSelectPin(rateSel),
    .rxAboveTrigger(rxAbove), .txSerialOut(txOut), .channelInterruptPinN(irqPin),
    .sampleTick(tick));
  ubt_rx_model rx_u (.clk, .line(txOut), .bitLen, .rxByte, .stopOk, .frames);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // the first two intervals after a divisor change may be partial, so skip them
  task automatic period(output int p);
    p = 0;
    repeat (2) do @(posedge clk); while (tick !== 1'b1);
    do begin
      @(posedge clk);
      p++;
    end while (tick !== 1'b1);
  endtask
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask
  task automatic give_verdict;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {rstn, psel, penable, pwrite, preSel, rateSel, rxAbove} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    {err_total, checks, bitLen} = {32'd0, 32'd0, 32'd16};
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, ubt_pkg::ADDR_LSR, 32'h0);
    chk(rd[6:5], 2'h3);
    foreach (rows[i]) begin
      preSel  <= rows[i].pre;
      rateSel <= rows[i].rate;
      apb(1'b1, ubt_pkg::ADDR_DLL, {24'h0, rows[i].dv});
      apb(1'b1, ubt_pkg::ADDR_DLM, 32'h0);
      period(n);
      chk(n, rows[i].dv * (rows[i].pre ? 4 : 1));
      bitLen = n * (rows[i].rate ? 16 : 8);
      n = frames;
      apb(1'b1, ubt_pkg::ADDR_THR, {24'h0, rows[i].b});
      apb(1'b0, ubt_pkg::ADDR_LSR, 32'h0);
      chk(rd[6], 1'b0);
      while (frames == n) @(posedge clk);
      chk({stopOk, rxByte}, {1'b1, rows[i].b});
      repeat (bitLen) @(posedge clk);
      apb(1'b0, ubt_pkg::ADDR_LSR, 32'h0);
      chk(rd[6:5], 2'h3);
    end
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk(irqPin, 1'b0);
    apb(1'b0, ubt_pkg::ADDR_DLL, 32'h0);
    chk(rd[7:0], ubt_pkg::DIV_RST[7:0]);
    apb(1'b0, ubt_pkg::ADDR_LSR, 32'h0);
    chk(rd[6:5], 2'h3);
    preSel <= 1'b1;
    apb(1'b1, ubt_pkg::ADDR_MCR, 32'h0);
    apb(1'b1, ubt_pkg::ADDR_DLL, 32'h2);
    period(n);
    chk(n, 2);
    apb(1'b1, ubt_pkg::ADDR_MCR, 32'h80);
    period(n);
    chk(n, 8);
    apb(1'b1, ubt_pkg::ADDR_DLL, 32'h0);
    settle;
    n = 0;
    repeat (40) begin
      @(posedge clk);
      n += (tick === 1'b1);
    end
    chk(n, 0);
    apb(1'b1, ubt_pkg::ADDR_DLL, 32'h1);
    apb(1'b1, ubt_pkg::ADDR_IER, 32'h2);
    settle;
    chk(irqPin, 1'b1);
    apb(1'b0, ubt_pkg::ADDR_ISR, 32'h0);
    chk(rd[2:0], 3'h2);
    apb(1'b1, ubt_pkg::ADDR_IER, 32'h0);
    settle;
    chk(irqPin, 1'b0);
    apb(1'b1, ubt_pkg::ADDR_FCR, 32'h1);
    apb(1'b1, ubt_pkg::ADDR_IER, 32'h1);
    rxAbove <= 1'b1;
    settle;
    chk(irqPin, 1'b1);
    rxAbove <= 1'b0;
    settle;
    chk(irqPin, 1'b0);
    // baud stopped so the fifo holds its bytes while the pin is checked
    apb(1'b1, ubt_pkg::ADDR_TRG, 32'h0);
    apb(1'b1, ubt_pkg::ADDR_DLL, 32'h0);
    apb(1'b1, ubt_pkg::ADDR_IER, 32'h2);
    apb(1'b1, ubt_pkg::ADDR_THR, 32'h5A);
    apb(1'b0, ubt_pkg::ADDR_RXL, 32'h0);
    chk(rd[7:0], 8'h01);
    apb(1'b1, ubt_pkg::ADDR_THR, 32'hC3);
    apb(1'b0, ubt_pkg::ADDR_RXL, 32'h0);
    chk(rd[7:0], 8'h02);
    settle;
    chk(irqPin, 1'b0);
    apb(1'b1, ubt_pkg::ADDR_FEATURE_CONTROL_REGISTER, 32'h8);
    settle;
    chk(irqPin, 1'b0);
    bitLen = 32;
    n = frames;
    apb(1'b1, ubt_pkg::ADDR_DLL, 32'h1);
    repeat (800) @(posedge clk);
    chk(frames, n + 2);
    chk(irqPin, 1'b1);
    apb(1'b0, ubt_pkg::ADDR_LSR, 32'h0);
    chk(rd[6:5], 2'h3);
    apb(1'b0, 8'h3C, 32'h0);
    chk(er, 1'b1);
    give_verdict;
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    give_verdict;
  end
endmodule
